// ### rtl/ise_pkg.sv
// Package with register map, field positions and reset values of the interval/event timer.
package ise_pkg;
   // Register byte offsets on the plain register port.
   localparam logic [7:0] ISE_OFS_MODE = 8'h00;
   localparam logic [7:0] ISE_OFS_PRESCALE = 8'h04;
   localparam logic [7:0] ISE_OFS_CMP_A = 8'h08;
   localparam logic [7:0] ISE_OFS_CMP_B = 8'h0C;
   localparam logic [7:0] ISE_OFS_OUT_CTL = 8'h10;
   localparam logic [7:0] ISE_OFS_COUNT = 8'h14;
   // Field positions.
   localparam int ISE_MODE_LO_BIT = 2;
   localparam int ISE_OUT_EN_BIT = 0;
   localparam int ISE_INV_A_BIT = 1;
   localparam int ISE_INV_B_BIT = 4;
   // Encodings of the mode and prescaler select fields.
   localparam logic [1:0] ISE_MODE_CLR_ON_MATCH = 2'h3;
   localparam logic [1:0] ISE_PRESCALE_EVENT = 2'h3;
   // Values after reset.
   localparam logic [1:0] ISE_MODE_RST = 2'h0;
   localparam logic [1:0] ISE_PRESCALE_RST = 2'h0;
   localparam logic [15:0] ISE_CMP_RST = 16'hFFFF;
   localparam logic [7:0] ISE_OUT_CTL_RST = 8'h00;
   localparam logic [15:0] ISE_COUNT_RST = 16'h0000;
endpackage

// ### rtl/ise_edge_filter.sv
// Synchroniser and two-sample noise filter for the event input pin.
`timescale 1ns/1ps
module ise_edge_filter (
   input wire logic clk,
   input wire logic rst,
   input wire logic pin_in,
   output logic rise_ff
);
   logic sync1_ff; // First stage, read only by the second stage.
   logic sync2_ff; // Second stage, safe to use.
   logic prev_ff; // Previous safe sample.
   logic level_ff; // Filtered level.

   // Two flip-flops bring the pin into the clock domain.
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         prev_ff <= 1'b0;
      end else begin
         sync1_ff <= pin_in;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // A new level is accepted only after two equal samples in a row, so a
   // one-sample glitch never reaches the counter.
   always_ff @(posedge clk) begin
      if (rst) begin
         level_ff <= 1'b0;
         rise_ff <= 1'b0;
      end else begin
         rise_ff <= 1'b0;
         if (sync2_ff == prev_ff && sync2_ff != level_ff) begin
            level_ff <= sync2_ff;
            rise_ff <= sync2_ff;
         end
      end
   end
endmodule

// ### rtl/ise_timer.sv
// Sixteen-bit clear-on-compare timer with square-wave output and event counting.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module ise_timer (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata_ff,
   input wire logic count_tick,
   input wire logic event_in_pin,
   output logic timer_out_pin_ff,
   output logic match_a_irq_ff,
   output logic match_b_irq_ff
);
   import ise_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and internal signals.
   logic [1:0] mode_ff; // Mode select field, hi and lo bits.
   logic [1:0] prescale_ff; // Count clock select field.
   logic [15:0] compare_a_ff; // First compare value.
   logic [15:0] compare_b_ff; // Second compare value.
   logic [7:0] out_ctl_ff; // Timer output control.
   logic [15:0] count_ff; // Running count value.
   logic run_ff; // Set once the first tick after start is absorbed.
   logic level_ff; // Internal square-wave level.
   logic event_rise; // Filtered valid edge of the event pin.
   logic tick; // Selected count clock enable.
   logic active; // Mode selects clear-on-compare operation.
   logic hit_a; // Counting tick while count equals compare A.
   logic hit_b; // Counting tick while count equals compare B.
   logic toggle; // Output level must flip.

   // Width-safe increment, shared by the counter and its check.
   function automatic logic [15:0] inc16(input logic [15:0] v);
      inc16 = v + 16'h0001;
   endfunction

   // Compare decode shared by both compare registers.
   function automatic logic match_now(input logic go, input logic [15:0] cnt,
      input logic [15:0] cmp);
      match_now = go && (cnt == cmp);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event pin conditioning.
   ise_edge_filter i_ise_edge_filter (
      .clk(clk),
      .rst(rst),
      .pin_in(event_in_pin),
      .rise_ff(event_rise)
   );

   // The event pin replaces the prescaler tick when selected.
   // Only a rising edge counts; a falling edge is never an event here.
   always_comb begin
      if (prescale_ff == ISE_PRESCALE_EVENT) begin
         tick = event_rise;
      end else begin
         tick = count_tick;
      end
   end

   // Match decode only counts on a tick of a running counter.
   always_comb begin
      active = (mode_ff == ISE_MODE_CLR_ON_MATCH);
      hit_a = match_now(active && run_ff && tick, count_ff, compare_a_ff);
      hit_b = match_now(active && run_ff && tick, count_ff, compare_b_ff);
      toggle = (hit_a && out_ctl_ff[ISE_INV_A_BIT]) || (hit_b && out_ctl_ff[ISE_INV_B_BIT]);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes.
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= ISE_MODE_RST;
         prescale_ff <= ISE_PRESCALE_RST;
         compare_a_ff <= ISE_CMP_RST;
         compare_b_ff <= ISE_CMP_RST;
         out_ctl_ff <= ISE_OUT_CTL_RST;
      end else if (wr_en) begin
         case (addr)
            ISE_OFS_MODE: begin
               mode_ff <= wdata[ISE_MODE_LO_BIT +: 2];
            end
            ISE_OFS_PRESCALE: begin
               prescale_ff <= wdata[1:0];
            end
            ISE_OFS_CMP_A: begin
               // Zero is forbidden here; hardware does not guard it.
               compare_a_ff <= wdata[15:0];
            end
            ISE_OFS_CMP_B: begin
               compare_b_ff <= wdata[15:0];
            end
            ISE_OFS_OUT_CTL: begin
               out_ctl_ff <= wdata[7:0];
            end
            default: begin
               // Unmapped and read-only offsets ignore writes.
            end
         endcase
      end
   end

   // Register reads, answered one cycle after the strobe.
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= 32'h0000_0000;
         if (rd_en) begin
            case (addr)
               ISE_OFS_MODE: rdata_ff <= {28'h0, mode_ff, 2'h0};
               ISE_OFS_PRESCALE: rdata_ff <= {30'h0, prescale_ff};
               ISE_OFS_CMP_A: rdata_ff <= {16'h0, compare_a_ff};
               ISE_OFS_CMP_B: rdata_ff <= {16'h0, compare_b_ff};
               ISE_OFS_OUT_CTL: rdata_ff <= {24'h0, out_ctl_ff};
               ISE_OFS_COUNT: rdata_ff <= {16'h0, count_ff};
               default: rdata_ff <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter. The first tick after the mode is entered only synchronises the
   // start, which is why the first event match needs one extra edge.
   always_ff @(posedge clk) begin
      if (rst) begin
         count_ff <= ISE_COUNT_RST;
         run_ff <= 1'b0;
      end else if (!active) begin
         count_ff <= ISE_COUNT_RST;
         run_ff <= 1'b0;
      end else if (tick) begin
         if (!run_ff) begin
            run_ff <= 1'b1;
         end else if (hit_a) begin
            count_ff <= ISE_COUNT_RST;
         end else begin
            count_ff <= inc16(count_ff);
         end
      end
   end

   // Match pulses, one cycle each.
   // The pulses are raw; masking an unused B pulse is left to software.
   always_ff @(posedge clk) begin
      if (rst) begin
         match_a_irq_ff <= 1'b0;
         match_b_irq_ff <= 1'b0;
      end else begin
         match_a_irq_ff <= hit_a;
         match_b_irq_ff <= hit_b;
      end
   end

   // Output level flips on selected matches; the pin shows it only while
   // the output is enabled, so disabling it parks the pin low.
   always_ff @(posedge clk) begin
      if (rst) begin
         level_ff <= 1'b0;
         timer_out_pin_ff <= 1'b0;
      end else begin
         if (toggle) begin
            level_ff <= ~level_ff;
         end
         timer_out_pin_ff <= out_ctl_ff[ISE_OUT_EN_BIT] && (toggle ? ~level_ff : level_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   // They watch only what the block drives; limits on what software writes,
   // such as the forbidden zero compare value, are not checked here.
   sequence s_hit_a;
      active && run_ff && tick && (count_ff == compare_a_ff);
   endsequence

   sequence s_count_step;
      active && run_ff && tick && (count_ff != compare_a_ff);
   endsequence

   sequence s_arm;
      active && !run_ff && tick;
   endsequence

   property p_clear_on_match;
      @(posedge clk) disable iff (rst) s_hit_a |=> (count_ff == 16'h0000) && match_a_irq_ff;
   endproperty
   a_clear_on_match: assert property (p_clear_on_match) else $error("no clear on match A");

   property p_irq_a_cause;
      @(posedge clk) disable iff (rst) match_a_irq_ff |-> $past(hit_a) && (count_ff == 16'h0000);
   endproperty
   a_irq_a_cause: assert property (p_irq_a_cause) else $error("stray match A pulse");

   property p_count_step;
      @(posedge clk) disable iff (rst) s_count_step |=> count_ff == inc16($past(count_ff));
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not advance");

   property p_irq_b;
      @(posedge clk) disable iff (rst)
         (hit_b && !hit_a) |=> match_b_irq_ff && (count_ff == inc16($past(count_ff)));
   endproperty
   a_irq_b: assert property (p_irq_b) else $error("match B wrong");

   property p_toggle_a;
      @(posedge clk) disable iff (rst)
         (hit_a && out_ctl_ff[ISE_INV_A_BIT] && !hit_b) |=> level_ff != $past(level_ff);
   endproperty
   a_toggle_a: assert property (p_toggle_a) else $error("no toggle on match A");

   property p_no_toggle;
      @(posedge clk) disable iff (rst) !match_a_irq_ff && !match_b_irq_ff |-> $stable(level_ff);
   endproperty
   a_no_toggle: assert property (p_no_toggle) else $error("toggle without match");

   property p_idle;
      @(posedge clk) disable iff (rst) !active |=> (count_ff == 16'h0000) && !run_ff;
   endproperty
   a_idle: assert property (p_idle) else $error("counter ran outside mode");

   property p_read_count;
      @(posedge clk) disable iff (rst)
         (rd_en && addr == ISE_OFS_COUNT) |=> rdata_ff == {16'h0, $past(count_ff)};
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read wrong");

   property p_first_tick;
      @(posedge clk) disable iff (rst)
         s_arm |=> run_ff && (count_ff == 16'h0000) && !match_a_irq_ff;
   endproperty
   a_first_tick: assert property (p_first_tick) else $error("start tick counted");

   property p_event_tick;
      @(posedge clk) disable iff (rst)
         (active && prescale_ff == ISE_PRESCALE_EVENT && !event_rise) |=> $stable(count_ff);
   endproperty
   a_event_tick: assert property (p_event_tick) else $error("event select ignored");

   // Compare B pulses only follow a real B match.
   property p_irq_b_cause;
      @(posedge clk) disable iff (rst) match_b_irq_ff |-> $past(hit_b);
   endproperty
   a_irq_b_cause: assert property (p_irq_b_cause) else $error("stray match B pulse");

   // Inversion on B alone flips the level once.
   property p_toggle_b;
      @(posedge clk) disable iff (rst)
         (hit_b && out_ctl_ff[ISE_INV_B_BIT] && !hit_a) |=> level_ff != $past(level_ff);
   endproperty
   a_toggle_b: assert property (p_toggle_b) else $error("no toggle on match B");

   // A disabled output parks the pin low on the next cycle.
   property p_pin_off;
      @(posedge clk) disable iff (rst) !out_ctl_ff[ISE_OUT_EN_BIT] |=> !timer_out_pin_ff;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin on while off");

   // An enabled pin shows the square-wave level without lag.
   property p_pin_follows;
      @(posedge clk) disable iff (rst)
         out_ctl_ff[ISE_OUT_EN_BIT] |=> timer_out_pin_ff == level_ff;
   endproperty
   a_pin_follows: assert property (p_pin_follows) else $error("pin lags level");

   // Read data stand for one cycle only and are zero otherwise.
   property p_rdata_idle;
      @(posedge clk) disable iff (rst) !rd_en |=> rdata_ff == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data stray");

   // Outside the clear-on-compare mode neither match pulse may appear.
   property p_idle_no_irq;
      @(posedge clk) disable iff (rst) !active |=> !match_a_irq_ff && !match_b_irq_ff;
   endproperty
   a_idle_no_irq: assert property (p_idle_no_irq) else $error("match outside mode");
endmodule

// ### verif/ise_event_src.sv
// Behavioural event source that drives the timer's event input pin.
`timescale 1ns/1ps
module ise_event_src (
   input wire logic clk,
   input wire logic fire,
   input wire logic wide,
   output logic event_in_pin
);
   // Cycles of high level still to drive on the pin.
   logic [2:0] left_ff = 3'h0;
   // A wide pulse lasts four cycles; a narrow one is one cycle of noise the filter must drop.
   always_ff @(posedge clk) begin
      if (fire) begin
         left_ff <= wide ? 3'h4 : 3'h1;
      end else if (left_ff != 3'h0) begin
         left_ff <= left_ff - 3'h1;
      end
   end
   // The pin is always driven, so it never floats between events.
   assign event_in_pin = (left_ff != 3'h0);
endmodule

// ### verif/interval_square_event_timer_tb_top.sv
// Self-checking testbench of the interval, square-wave and event timer.
`timescale 1ns/1ps
module interval_square_event_timer_tb_top;
   import ise_pkg::*;
   logic clk, rst, wr_en, rd_en, count_tick, fire, wide, ev_pin, pin, irq_a, irq_b;
   logic pin_q = 1'b0;
   logic [7:0] addr;
   logic [31:0] wdata, rdata_ff;
   int n_fail = 0, samples_checked = 0, n_a = 0, n_b = 0, n_tog = 0, s_a, s_b, s_t, c;
   // Reset rows: address read and the value it must give, the last one unmapped.
   logic [7:0] row_a [7] = '{ISE_OFS_MODE, ISE_OFS_PRESCALE, ISE_OFS_CMP_A, ISE_OFS_CMP_B,
      ISE_OFS_OUT_CTL, ISE_OFS_COUNT, 8'h18};
   logic [31:0] row_d [7] = '{32'(ISE_MODE_RST) << ISE_MODE_LO_BIT, 32'(ISE_PRESCALE_RST),
      32'(ISE_CMP_RST), 32'(ISE_CMP_RST), 32'(ISE_OUT_CTL_RST), 32'(ISE_COUNT_RST), 32'h0};

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   ise_timer i_ise_timer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata_ff(rdata_ff), .count_tick(count_tick), .event_in_pin(ev_pin),
      .timer_out_pin_ff(pin), .match_a_irq_ff(irq_a), .match_b_irq_ff(irq_b));
   ise_event_src i_ise_event_src (.clk(clk), .fire(fire), .wide(wide), .event_in_pin(ev_pin));

   ////////////////////////////////////////////////////////////////////////////////
   // Running tallies of pulses and pin changes, so windows can be judged by difference.
   always @(posedge clk) begin
      pin_q <= pin;
      if (irq_a === 1'b1) n_a <= n_a + 1;
      if (irq_b === 1'b1) n_b <= n_b + 1;
      if (pin !== pin_q) n_tog <= n_tog + 1;
   end

   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // One-cycle write strobe beside address and data.
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data is only valid in the cycle after the strobe, so it is sampled there.
   task rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(what, rdata_ff, exp);
   endtask

   // Waits for a compare A pulse and returns the edges it took; a hang ends the run.
   task wait_a(output int cyc);
      int i;
      for (i = 0; i < 200; i++) begin
         @(posedge clk);
         #1;
         if (irq_a === 1'b1) break;
      end
      cyc = i + 1;
      if (i == 200) begin
         n_fail++;
         wrap_up();
      end
   endtask

   // Sends k event pulses, wide or narrow, with a quiet gap after each.
   task pulse(input logic w, input int k);
      repeat (k) begin
         @(posedge clk);
         fire <= 1'b1;
         wide <= w;
         @(posedge clk);
         fire <= 1'b0;
         repeat (12) @(posedge clk);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      {wr_en, rd_en, count_tick, fire, wide} = 5'h00;
      addr = 8'h00;
      wdata = 32'h0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int r = 0; r < 7; r++) rd("reset value", row_a[r], row_d[r]);
      $display("test reset values done");
      // Compare A of three gives a four-tick period; B sits inside it and must not clear.
      wr(ISE_OFS_CMP_A, 32'h3);
      wr(ISE_OFS_CMP_B, 32'h1);
      count_tick <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(ISE_OFS_MODE, 32'h0);
         wr(ISE_OFS_OUT_CTL, 32'h1 | (32'(s & 1) << ISE_INV_A_BIT)
            | (32'(s >> 1) << ISE_INV_B_BIT));
         wr(ISE_OFS_MODE, 32'(ISE_MODE_CLR_ON_MATCH) << ISE_MODE_LO_BIT);
         wait_a(c);
         wait_a(c);
         chk("match period", c, 4);
         #1 {s_a, s_b, s_t} = {n_a, n_b, n_tog};
         repeat (40) @(posedge clk);
         #1 chk("a matches", n_a - s_a, 10);
         // The raw B pulse is counted here; masking it is left to software.
         chk("b matches", n_b - s_b, 10);
         chk("pin toggles", n_tog - s_t, 10 * (s & 1) + 10 * (s >> 1));
      end
      // Ticks stop just after a clear, so the count must have moved exactly once.
      wait_a(c);
      @(posedge clk);
      count_tick <= 1'b0;
      rd("count", ISE_OFS_COUNT, 32'h1);
      $display("test interval and square wave done");
      wr(ISE_OFS_MODE, 32'h0);
      wr(ISE_OFS_PRESCALE, 32'(ISE_PRESCALE_EVENT));
      // Prescaler ticks keep running and must be ignored while the pin is selected.
      count_tick <= 1'b1;
      wr(ISE_OFS_CMP_A, 32'h2);
      wr(ISE_OFS_MODE, 32'(ISE_MODE_CLR_ON_MATCH) << ISE_MODE_LO_BIT);
      s_a = n_a;
      pulse(1'b0, 1);
      pulse(1'b1, 3);
      #1 chk("event matches", n_a - s_a, 0);
      pulse(1'b1, 1);
      #1 chk("event matches", n_a - s_a, 1);
      pulse(1'b1, 2);
      #1 chk("event matches", n_a - s_a, 1);
      pulse(1'b1, 1);
      #1 chk("event matches", n_a - s_a, 2);
      $display("test event counting done");
      // A reset in mid-run must bring the pin, both match pulses, mode, compare A and count back at once.
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      #1 chk("pin after reset", pin, 32'h0);
      chk("match a after reset", irq_a, 32'h0);
      chk("match b after reset", irq_b, 32'h0);
      rd("mode after reset", ISE_OFS_MODE, 32'(ISE_MODE_RST) << ISE_MODE_LO_BIT);
      rd("compare a after reset", ISE_OFS_CMP_A, 32'(ISE_CMP_RST));
      rd("count after reset", ISE_OFS_COUNT, 32'(ISE_COUNT_RST));
      $display("test mid-run reset done");
      // With the output disabled, matches go on but the pin must stay low.
      wr(ISE_OFS_CMP_A, 32'h3);
      wr(ISE_OFS_OUT_CTL, 32'h1 << ISE_INV_A_BIT);
      wr(ISE_OFS_MODE, 32'(ISE_MODE_CLR_ON_MATCH) << ISE_MODE_LO_BIT);
      wait_a(c);
      chk("first interval", c, 5);
      #1 s_t = n_tog;
      repeat (20) @(posedge clk);
      #1 chk("pin toggles disabled", n_tog - s_t, 0);
      chk("pin disabled", pin, 32'h0);
      $display("test disabled output done");
      wrap_up();
   end
endmodule
